/* File: hdl/ddiq_pkg.sv */
// Constants, state codes and sample-format helpers for the dual I/Q input path.
// Assumes one system clock; every slower event arrives as a sampled level.
package ddiq_pkg;

  // ==========================================================================
  // Sample format
  localparam int SAMPLE_W = 10;
  localparam int SAMPLE_MSB = SAMPLE_W - 1;
  localparam logic [9:0] MID_CODE = 10'h200;
  localparam logic [9:0] ZERO_CODE = 10'h000;

  // ==========================================================================
  // Half-band interpolator, 43 taps, every other tap zero except the centre
  localparam int FIR_TAPS = 43;
  localparam int HIST_LEN = (FIR_TAPS + 1) / 2;
  localparam int CENTER_IDX = 10;
  localparam logic signed [12:0] CENTER_COEF = 13'sh07CE;
  localparam int COEF_SHIFT = 11;
  localparam logic signed [12:0] HALF_COEF [0:10] = '{
    13'sh0001, -13'sh0003, 13'sh0008, -13'sh0010, 13'sh001D, -13'sh0032,
    13'sh0051, -13'sh0083, 13'sh00D8, -13'sh0190, 13'sh04F0};

  // ==========================================================================
  // Latency, counted in converter clock periods
  localparam int LAT_I = 55;
  localparam int LAT_Q = 56;
  localparam int FIR_DELAY = (FIR_TAPS - 1) / 2;
  localparam int DLY_I = LAT_I - FIR_DELAY;
  localparam int DLY_Q = LAT_Q - FIR_DELAY;

  // ==========================================================================
  // Reset / power-down control
  localparam logic [2:0] SLEEP_EDGES = 3'h4;

  typedef enum logic [1:0] {
    DDIQ_RUN = 2'b00,
    DDIQ_HELD = 2'b01,
    DDIQ_SLEEP = 2'b10
  } ddiq_state_t;

  // Offset binary to two's complement
  function automatic logic signed [9:0] ddiq_to_signed(input logic [9:0] code);
    ddiq_to_signed = {~code[SAMPLE_MSB], code[SAMPLE_MSB-1:0]};
  endfunction

  // Two's complement to offset binary
  function automatic logic [9:0] ddiq_to_code(input logic signed [9:0] s);
    ddiq_to_code = {~s[SAMPLE_MSB], s[SAMPLE_MSB-1:0]};
  endfunction

endpackage

/* File: hdl/ddiq_hbf.sv */
// One channel of 2x half-band interpolation plus the latency-matching delay line.
// Assumes step is a one-cycle pulse per converter edge and phase alternates with it.
`timescale 1ns/10ps
module ddiq_hbf
  import ddiq_pkg::*;
#(
  parameter int DLY = DLY_I
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic step,
  input wire logic phase,
  input wire logic [9:0] din,
  output logic [9:0] dout
);

  logic signed [9:0] hist [0:HIST_LEN-1];
  logic signed [9:0] next_hist [0:HIST_LEN-1];
  logic [9:0] dly [0:DLY-1];
  logic [9:0] next_dly [0:DLY-1];
  logic signed [24:0] acc;
  logic signed [24:0] scaled;

  function automatic logic signed [12:0] tap_coef(input int k);
    tap_coef = (k <= CENTER_IDX) ? HALF_COEF[k] : HALF_COEF[HIST_LEN-1-k];
  endfunction

  function automatic logic signed [9:0] sat10(input logic signed [24:0] v);
    if (v > 25'sd511) begin
      sat10 = 10'sh1FF;
    end else if (v < -25'sd512) begin
      sat10 = -10'sh200;
    end else begin
      sat10 = v[9:0];
    end
  endfunction

  // ==========================================================================
  // Filter datapath
  always_comb begin
    next_hist = hist;
    next_dly = dly;
    acc = '0;
    scaled = '0;
    if (clear) begin
      next_hist = '{default: '0};
      next_dly = '{default: MID_CODE};
    end else if (step) begin
      if (!phase) begin
        // Even output: new sample shifts in, odd-numbered taps apply
        next_hist[0] = ddiq_to_signed(din);
        for (int k = 1; k < HIST_LEN; k++) begin
          next_hist[k] = hist[k-1];
        end
        for (int k = 0; k < HIST_LEN; k++) begin
          acc = acc + tap_coef(k) * next_hist[k];
        end
      end else begin
        // Odd output: only the centre tap is non-zero
        acc = CENTER_COEF * hist[CENTER_IDX];
      end
      scaled = acc >>> COEF_SHIFT;
      next_dly[0] = ddiq_to_code(sat10(scaled));
      for (int k = 1; k < DLY; k++) begin
        next_dly[k] = dly[k-1];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hist <= '{default: '0};
      dly <= '{default: MID_CODE};
    end else begin
      hist <= next_hist;
      dly <= next_dly;
    end
  end

  assign dout = dly[DLY-1];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_hist_take;
    step && !phase && !clear |=> hist[0] == ddiq_to_signed($past(din));
  endproperty
  a_hist_take: assert property (p_hist_take) else $error("sample not taken into filter");

  property p_hold_idle;
    !step && !clear |=> $stable(dout) && $stable(hist[0]);
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("filter moved without an edge");

endmodule

/* File: hdl/ddiq_top.sv */
// Input interface of a dual I/Q converter: de-interleave, interpolate, update.
// Assumes all pins are synchronous to CLK_SYS, which runs well above the
// converter clock so that every edge of CONV_CLK and WR_STROBE is seen.
//
// Notes on behaviour
// - Ten-bit sample bus, bit nine most significant, plain binary weighting.
// - Each rising write strobe while running captures the bus into a channel register.
// - Select high writes the I register, select low the Q register.
// - Each rising converter clock while running updates I and Q outputs together.
// - On every other such edge each filter reads its own channel register.
// - Control held four or more converter clocks puts the device to sleep.
// - Control held fewer than four converter clocks acts as a reset only.
// - True output full scale at all ones, complement at all zeros.
// - Sample to update takes 55 periods for I and 56 for Q.
// - Each channel has a 43-tap half-band filter doubling the rate.
`timescale 1ns/10ps
module ddiq_top
  import ddiq_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [9:0] SAMPLE_BUS,
  input wire logic WR_STROBE,
  input wire logic CHAN_SEL,
  input wire logic CONV_CLK,
  input wire logic RST_SLEEP,
  output logic [9:0] I_TRUE_OUTPUT,
  output logic [9:0] I_COMPLEMENT_OUTPUT,
  output logic [9:0] Q_TRUE_OUTPUT,
  output logic [9:0] Q_COMPLEMENT_OUTPUT,
  output logic SLEEP_ACTIVE
);

  // ==========================================================================
  // Edge detection on the strobe pins
  logic wr_prev;
  logic conv_prev;
  logic wr_edge;
  logic conv_edge;

  // No reset: the flops follow the pins through reset, so a pin that is
  // already high at release gives no false edge
  always_ff @(posedge CLK_SYS) begin
    wr_prev <= WR_STROBE;
    conv_prev <= CONV_CLK;
  end

  assign wr_edge = WR_STROBE & ~wr_prev;
  assign conv_edge = CONV_CLK & ~conv_prev;

  // ==========================================================================
  // Reset / power-down control
  ddiq_state_t state;
  ddiq_state_t next_state;
  logic [2:0] held_cnt;
  logic [2:0] next_held_cnt;
  logic clear_pulse;
  logic next_clear_pulse;
  logic run;

  // Counting converter edges, not system cycles, keeps the threshold
  // independent of the ratio between the two clocks.
  always_comb begin
    next_state = state;
    next_held_cnt = held_cnt;
    next_clear_pulse = 1'b0;
    case (state)
      DDIQ_RUN: begin
        if (RST_SLEEP) begin
          next_state = DDIQ_HELD;
          next_held_cnt = 3'h0;
        end
      end
      DDIQ_HELD: begin
        if (!RST_SLEEP) begin
          next_state = DDIQ_RUN;
          next_clear_pulse = 1'b1;
        end else if (conv_edge) begin
          if (held_cnt == SLEEP_EDGES - 3'h1) begin
            next_state = DDIQ_SLEEP;
          end else begin
            next_held_cnt = held_cnt + 3'h1;
          end
        end
      end
      DDIQ_SLEEP: begin
        // Waking always starts from a clean state
        if (!RST_SLEEP) begin
          next_state = DDIQ_RUN;
          next_clear_pulse = 1'b1;
        end
      end
      default: begin
        next_state = DDIQ_RUN;
        next_clear_pulse = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state <= DDIQ_RUN;
      held_cnt <= 3'h0;
      clear_pulse <= 1'b0;
    end else begin
      state <= next_state;
      held_cnt <= next_held_cnt;
      clear_pulse <= next_clear_pulse;
    end
  end

  assign run = (state == DDIQ_RUN) && !clear_pulse;
  assign SLEEP_ACTIVE = (state == DDIQ_SLEEP);

  // ==========================================================================
  // Channel input registers and I/Q pairing phase
  logic [9:0] i_reg;
  logic [9:0] q_reg;
  logic phase;
  logic [9:0] next_i_reg;
  logic [9:0] next_q_reg;
  logic next_phase;
  logic step;

  assign step = conv_edge && run;

  // Writes during a held reset are dropped: the data would be cleared anyway
  always_comb begin
    next_i_reg = i_reg;
    next_q_reg = q_reg;
    next_phase = phase;
    if (clear_pulse) begin
      next_i_reg = ZERO_CODE;
      next_q_reg = ZERO_CODE;
      next_phase = 1'b0;
    end else if (run) begin
      if (wr_edge && CHAN_SEL) begin
        next_i_reg = SAMPLE_BUS;
      end
      if (wr_edge && !CHAN_SEL) begin
        next_q_reg = SAMPLE_BUS;
      end
      if (step) begin
        next_phase = ~phase;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      i_reg <= ZERO_CODE;
      q_reg <= ZERO_CODE;
      phase <= 1'b0;
    end else begin
      i_reg <= next_i_reg;
      q_reg <= next_q_reg;
      phase <= next_phase;
    end
  end

  // ==========================================================================
  // Interpolators; Q runs one period longer to meet its pairing latency
  logic [9:0] i_code;
  logic [9:0] q_code;

  ddiq_hbf #(.DLY(DLY_I)) u_fir_i (
    .clk(CLK_SYS),
    .nrst(NRST),
    .clear(clear_pulse),
    .step(step),
    .phase(phase),
    .din(i_reg),
    .dout(i_code)
  );

  ddiq_hbf #(.DLY(DLY_Q)) u_fir_q (
    .clk(CLK_SYS),
    .nrst(NRST),
    .clear(clear_pulse),
    .step(step),
    .phase(phase),
    .din(q_reg),
    .dout(q_code)
  );

  // ==========================================================================
  // Output stage: true and complementary codes, both channels on one edge
  logic [9:0] next_i_true;
  logic [9:0] next_i_comp;
  logic [9:0] next_q_true;
  logic [9:0] next_q_comp;

  // Asleep, both legs carry no current
  always_comb begin
    if (SLEEP_ACTIVE) begin
      next_i_true = ZERO_CODE;
      next_i_comp = ZERO_CODE;
      next_q_true = ZERO_CODE;
      next_q_comp = ZERO_CODE;
    end else begin
      next_i_true = i_code;
      next_i_comp = ~i_code;
      next_q_true = q_code;
      next_q_comp = ~q_code;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      I_TRUE_OUTPUT <= MID_CODE;
      I_COMPLEMENT_OUTPUT <= ~MID_CODE;
      Q_TRUE_OUTPUT <= MID_CODE;
      Q_COMPLEMENT_OUTPUT <= ~MID_CODE;
    end else begin
      I_TRUE_OUTPUT <= next_i_true;
      I_COMPLEMENT_OUTPUT <= next_i_comp;
      Q_TRUE_OUTPUT <= next_q_true;
      Q_COMPLEMENT_OUTPUT <= next_q_comp;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  property p_write_i;
    run && wr_edge && CHAN_SEL |=> i_reg == $past(SAMPLE_BUS) && $stable(q_reg);
  endproperty
  a_write_i: assert property (p_write_i) else $error("I write not captured");

  property p_write_q;
    run && wr_edge && !CHAN_SEL |=> q_reg == $past(SAMPLE_BUS) && $stable(i_reg);
  endproperty
  a_write_q: assert property (p_write_q) else $error("Q write misrouted");

  property p_complement;
    !SLEEP_ACTIVE && !$past(SLEEP_ACTIVE) |-> I_COMPLEMENT_OUTPUT == ~I_TRUE_OUTPUT
      && Q_COMPLEMENT_OUTPUT == ~Q_TRUE_OUTPUT;
  endproperty
  a_complement: assert property (p_complement) else $error("complement leg wrong");

  property p_sleep_entry;
    state == DDIQ_HELD && RST_SLEEP && conv_edge && held_cnt == 3'h3
      |=> SLEEP_ACTIVE ##1 (I_TRUE_OUTPUT == ZERO_CODE && Q_TRUE_OUTPUT == ZERO_CODE);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep after four edges");

  property p_no_early_sleep;
    state == DDIQ_HELD && held_cnt < SLEEP_EDGES - 3'h1 |=> !SLEEP_ACTIVE;
  endproperty
  a_no_early_sleep: assert property (p_no_early_sleep) else $error("slept too early");

  property p_short_reset;
    state == DDIQ_HELD && !RST_SLEEP |=> clear_pulse ##1 (state == DDIQ_RUN
      && i_reg == ZERO_CODE && q_reg == ZERO_CODE && !phase);
  endproperty
  a_short_reset: assert property (p_short_reset) else $error("short pulse not a reset");

  property p_phase_step;
    step |=> phase != $past(phase);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("pairing phase stuck");

  property p_update_sync;
    $changed(I_TRUE_OUTPUT) || $changed(Q_TRUE_OUTPUT) |-> $past(step, 2)
      || $past(clear_pulse, 2) || SLEEP_ACTIVE || $past(SLEEP_ACTIVE) || $past(SLEEP_ACTIVE, 2);
  endproperty
  a_update_sync: assert property (p_update_sync) else $error("output moved off the edge");

  c_sleep: cover property (state == DDIQ_HELD ##1 SLEEP_ACTIVE);
  c_short_reset: cover property (state == DDIQ_HELD ##1 clear_pulse);
  c_pair: cover property (run && wr_edge && CHAN_SEL ##[1:20] run && wr_edge && !CHAN_SEL);
  c_update: cover property (step ##2 $changed(I_TRUE_OUTPUT));

endmodule

/* File: test/ddiq_host.sv */
// Host model: drives interleaved I/Q words, the converter clock and the control pin.
// Assumes the bench calls its tasks; every change lands on a falling clk edge.
`timescale 1ns/10ps
module ddiq_host
  import ddiq_pkg::*;
(
  input wire logic clk,
  output logic [9:0] bus,
  output logic wr,
  output logic sel,
  output logic conv,
  output logic ctl
);
  initial begin
    bus = MID_CODE;
    wr = 1'b0;
    sel = 1'b0;
    conv = 1'b0;
    ctl = 1'b0;
  end

  // ==========================================================================
  // Pair transfer: converter edge kept one cycle away from each write edge
  task automatic send_pair(input logic [9:0] iw, input logic [9:0] qw);
    @(negedge clk);
    bus = iw;
    sel = 1'b1;
    wr = 1'b1;
    conv = 1'b0;
    @(negedge clk);
    bus = ~iw; // Released bus never shows the stale word
    wr = 1'b0;
    conv = 1'b1;
    @(negedge clk);
    bus = qw;
    sel = 1'b0;
    wr = 1'b1;
    conv = 1'b0;
    @(negedge clk);
    bus = ~qw;
    wr = 1'b0;
    conv = 1'b1;
  endtask

  // ==========================================================================
  // Bare converter edges, no writes
  task automatic conv_edges(input int n);
    repeat (n) begin
      @(negedge clk);
      conv = 1'b0;
      @(negedge clk);
      conv = 1'b1;
    end
    @(negedge clk);
    conv = 1'b0;
  endtask

  task automatic set_ctl(input logic v);
    @(negedge clk);
    ctl = v;
  endtask
endmodule

/* File: test/ddiq_tb.sv */
// Self-checking bench for the dual I/Q input path.
// Assumes the host model drives every input except clock and reset.
`timescale 1ns/10ps
module tb;
  import ddiq_pkg::*;
  logic clk_sys;
  logic nrst;
  logic [9:0] bus;
  logic wr;
  logic sel;
  logic conv;
  logic ctl;
  logic [9:0] i_true;
  logic [9:0] i_comp;
  logic [9:0] q_true;
  logic [9:0] q_comp;
  logic sleep;
  int fails = 0;
  int check_count = 0;
  logic armed = 1'b0;
  time arm_t = 0;
  time i_t = 0;
  time q_t = 0;

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  ddiq_top ddiq_top_i (
    .CLK_SYS(clk_sys), .NRST(nrst), .SAMPLE_BUS(bus), .WR_STROBE(wr), .CHAN_SEL(sel),
    .CONV_CLK(conv), .RST_SLEEP(ctl), .I_TRUE_OUTPUT(i_true), .I_COMPLEMENT_OUTPUT(i_comp),
    .Q_TRUE_OUTPUT(q_true), .Q_COMPLEMENT_OUTPUT(q_comp), .SLEEP_ACTIVE(sleep)
  );

  ddiq_host ddiq_host_i (
    .clk(clk_sys), .bus(bus), .wr(wr), .sel(sel), .conv(conv), .ctl(ctl)
  );

  // First departure from midscale on each channel; sampled mid-cycle,
  // where the registered outputs have settled and times are whole ns
  always @(negedge clk_sys) begin
    if (armed && i_t == 0 && i_true !== MID_CODE) i_t = $time;
    if (armed && q_t == 0 && q_true !== MID_CODE) q_t = $time;
  end

  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_outs(input logic [9:0] ie, input logic [9:0] ic, input logic [9:0] qe,
                          input logic [9:0] qc, input logic se);
    chk(i_true, ie, "I true leg");
    chk(i_comp, ic, "I complement leg");
    chk(q_true, qe, "Q true leg");
    chk(q_comp, qc, "Q complement leg");
    chk({9'h000, sleep}, {9'h000, se}, "sleep flag");
  endtask

  // DC gain of the interpolator: coefficient sum equals the centre tap
  function automatic logic [9:0] dc_code(input int s);
    int p;
    p = (s * int'(CENTER_COEF)) >>> COEF_SHIFT;
    return 10'(p + 512);
  endfunction

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset_values();
    chk_outs(MID_CODE, 10'h1FF, MID_CODE, 10'h1FF, 1'b0);
  endtask

  task automatic test_dc_latency();
    logic [9:0] ie;
    logic [9:0] qe;
    ie = dc_code(-512);
    qe = dc_code(-256);
    @(negedge clk_sys);
    armed = 1'b1;
    arm_t = $time;
    repeat (45) ddiq_host_i.send_pair(10'h000, 10'h100);
    repeat (4) @(negedge clk_sys);
    chk_outs(ie, ~ie, qe, ~qe, 1'b0);
    chk(10'((q_t - i_t) / 50), 10'h001, "Q lag behind I in steps");
    chk({9'h000, i_t - arm_t > 1600}, 10'h001, "I update too early");
    ddiq_host_i.send_pair(10'h3FF, 10'h000);
    repeat (4) @(negedge clk_sys);
    chk(i_comp, ~i_true, "I legs not complementary");
  endtask

  task automatic test_short_reset();
    ddiq_host_i.set_ctl(1'b1);
    ddiq_host_i.conv_edges(3);
    repeat (3) @(negedge clk_sys);
    chk({9'h000, sleep}, 10'h000, "sleep after three edges");
    ddiq_host_i.set_ctl(1'b0);
    repeat (4) @(negedge clk_sys);
    chk_outs(MID_CODE, 10'h1FF, MID_CODE, 10'h1FF, 1'b0);
    ddiq_host_i.conv_edges(10);
    repeat (3) @(negedge clk_sys);
    chk_outs(MID_CODE, 10'h1FF, MID_CODE, 10'h1FF, 1'b0);
  endtask

  task automatic test_sleep();
    repeat (20) ddiq_host_i.send_pair(10'h3FF, 10'h000);
    ddiq_host_i.set_ctl(1'b1);
    ddiq_host_i.conv_edges(4);
    repeat (3) @(negedge clk_sys);
    chk_outs(ZERO_CODE, ZERO_CODE, ZERO_CODE, ZERO_CODE, 1'b1);
    ddiq_host_i.send_pair(10'h3FF, 10'h3FF);
    chk_outs(ZERO_CODE, ZERO_CODE, ZERO_CODE, ZERO_CODE, 1'b1);
    ddiq_host_i.set_ctl(1'b0);
    repeat (4) @(negedge clk_sys);
    chk_outs(MID_CODE, 10'h1FF, MID_CODE, 10'h1FF, 1'b0);
  endtask

  // Reset in mid-run while asleep and with the control pin still held
  task automatic test_mid_reset();
    ddiq_host_i.set_ctl(1'b1);
    ddiq_host_i.conv_edges(4);
    @(negedge clk_sys);
    chk({9'h000, sleep}, 10'h001, "not asleep before reset");
    nrst = 1'b0;
    @(negedge clk_sys);
    chk_outs(MID_CODE, 10'h1FF, MID_CODE, 10'h1FF, 1'b0);
    nrst = 1'b1;
    ddiq_host_i.conv_edges(1);
    repeat (2) @(negedge clk_sys);
    chk_outs(MID_CODE, 10'h1FF, MID_CODE, 10'h1FF, 1'b0);
    ddiq_host_i.set_ctl(1'b0);
    repeat (4) @(negedge clk_sys);
    chk_outs(MID_CODE, 10'h1FF, MID_CODE, 10'h1FF, 1'b0);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    nrst = 1'b0;
    repeat (6) @(negedge clk_sys);
    test_reset_values();
    nrst = 1'b1;
    @(negedge clk_sys);
    test_reset_values();
    test_dc_latency();
    test_short_reset();
    test_sleep();
    test_mid_reset();
    complete_run();
  end

  // Whole sequence needs about 365 cycles; allow a wide margin
  initial begin
    #100000;
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
